// ### core/srcc_clock_control.sv
// suspend/resume clock switch, oscillator enables, select hold and refresh
`timescale 1ns/1ns
`include "srcc_defines.svh"
// How it works
// - output fast clock normally, 32.768 KHz clock while suspended
// - standby refresh pulses low once every 15.26 microseconds
// - each refresh low pulse lasts 1.0 microsecond
// - alternate 124 microsecond refresh clock exists; the 15.26 figure is used
// - refresh pulse runs all the time, suspended or not
// - serial A, serial B, parallel selects held low throughout suspend
// - codes count only when the write strobe is active
// - suspend: 16 MHz osc off, glitch-free switch to 32 KHz, then 14 MHz off
// - suspend code drives all three selects low in one cycle
// - resume code re-enables both oscillators and releases selects
// - about 20 ms after resume, switch clock back to 14.318 MHz
module srcc_clock_control
   import srcc_pkg::*;
#(
   parameter int STAB_CYC = `SRCC_STAB_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // encoded select bus from the system controller
   input wire logic [`SRCC_CODE_W-1:0] select_code,
   input wire logic io_write_strobe_n,
   // oscillator levels, synchronous to clk
   input wire logic osc14_in,
   input wire logic osc32_in,
   // oscillator enables
   output logic osc16_enable,
   output logic osc14_enable,
   // clock to the system controller
   output logic fast_clk_out,
   // active-low selects to the companion chip
   output logic serial_a_select_n,
   output logic serial_b_select_n,
   output logic parallel_select_n,
   // refresh pad and status
   output logic standby_refresh_pulse_n,
   output logic suspended
);

   localparam logic [22:0] STAB_LAST = 23'(STAB_CYC - 1);

   srcc_main_t s_r;
   srcc_main_t s_nxt;

   // strobed code match, used for both the suspend and the resume code
   function automatic logic code_hit(input logic [`SRCC_CODE_W-1:0] code,
                                     input logic strobe_n,
                                     input logic [`SRCC_CODE_W-1:0] want);
      code_hit = !strobe_n && (code == want);
   endfunction

   logic go_susp;
   logic go_res;
   logic both_low;

   assign go_susp = code_hit(select_code, io_write_strobe_n, `SRCC_CODE_SUSPEND);
   assign go_res = code_hit(select_code, io_write_strobe_n, `SRCC_CODE_RESUME);
   // switching only while both sources are low keeps the output free of runt pulses
   assign both_low = !osc14_in && !osc32_in;

   // sequencer
   always_comb begin
      s_nxt = s_r;
      s_nxt.clk_out = s_r.sel32 ? osc32_in : osc14_in;
      case (s_r.state)
         SRCC_RUN: begin
            if (go_susp) begin
               s_nxt.state = SRCC_KILL16;
               s_nxt.osc16_en = 1'h0;
               s_nxt.sel_n = 3'h0;
            end
         end
         SRCC_KILL16: begin
            s_nxt.state = SRCC_SW32;
         end
         SRCC_SW32: begin
            if (go_res) begin
               s_nxt.state = SRCC_WAKE;
               s_nxt.osc16_en = 1'h1;
               s_nxt.sel_n = `SRCC_RST_SEL_N;
               s_nxt.cnt = 23'h000000;
            end else if (both_low) begin
               s_nxt.sel32 = 1'h1;
               s_nxt.state = SRCC_SUSP;
            end
         end
         SRCC_SUSP: begin
            s_nxt.osc14_en = 1'h0;
            if (go_res) begin
               s_nxt.state = SRCC_WAKE;
               s_nxt.osc16_en = 1'h1;
               s_nxt.osc14_en = 1'h1;
               s_nxt.sel_n = `SRCC_RST_SEL_N;
               s_nxt.cnt = 23'h000000;
            end
         end
         SRCC_WAKE: begin
            // a fresh suspend during the settle wait is honoured at once
            if (go_susp) begin
               s_nxt.state = SRCC_KILL16;
               s_nxt.osc16_en = 1'h0;
               s_nxt.sel_n = 3'h0;
            end else if (s_r.cnt == STAB_LAST) begin
               s_nxt.state = SRCC_SW14;
            end else begin
               s_nxt.cnt = s_r.cnt + 23'h000001;
            end
         end
         SRCC_SW14: begin
            if (both_low) begin
               s_nxt.sel32 = 1'h0;
               s_nxt.state = SRCC_RUN;
            end
         end
         default: begin
            s_nxt.state = SRCC_RUN;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_r.state <= SRCC_RUN;
         s_r.sel32 <= 1'h0;
         s_r.clk_out <= 1'h0;
         s_r.osc16_en <= `SRCC_RST_OSC_EN;
         s_r.osc14_en <= `SRCC_RST_OSC_EN;
         s_r.sel_n <= `SRCC_RST_SEL_N;
         s_r.cnt <= 23'h000000;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from the register
   assign osc16_enable = s_r.osc16_en;
   assign osc14_enable = s_r.osc14_en;
   assign fast_clk_out = s_r.clk_out;
   assign serial_a_select_n = s_r.sel_n[0];
   assign serial_b_select_n = s_r.sel_n[1];
   assign parallel_select_n = s_r.sel_n[2];
   assign suspended = s_r.sel32;

   // refresh is independent of the sequencer
   srcc_refresh u_refresh (
      .clk(clk),
      .sys_rst(sys_rst),
      .standby_refresh_pulse_n(standby_refresh_pulse_n)
   );

   property p_clk_src;
      @(posedge clk) disable iff (sys_rst)
      // the edge right after reset still shows the reset value, not the source
      (!$past(sys_rst) && !$past(s_r.sel32) && !s_r.sel32) |-> fast_clk_out == $past(osc14_in, 1);
   endproperty
   a_clk_src: assert property (p_clk_src) else $error("fast clock not from 14 MHz source");

   property p_sel_hold;
      @(posedge clk) disable iff (sys_rst)
      (s_r.state == SRCC_SUSP) |-> (s_r.sel_n == 3'h0 && s_r.sel32);
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("selects not low while suspended");

   property p_strobe_qual;
      @(posedge clk) disable iff (sys_rst)
      (s_r.state == SRCC_RUN && io_write_strobe_n) |=> s_r.state == SRCC_RUN;
   endproperty
   a_strobe_qual: assert property (p_strobe_qual) else $error("left run without a write strobe");

   property p_kill_order;
      @(posedge clk) disable iff (sys_rst)
      $fell(osc14_enable) |-> (s_r.sel32 && !osc16_enable && $past(s_r.sel32));
   endproperty
   a_kill_order: assert property (p_kill_order) else $error("14 MHz osc stopped before switch");

   property p_sel_same;
      @(posedge clk) disable iff (sys_rst)
      (s_r.state == SRCC_RUN && go_susp) |=>
         (!serial_a_select_n && !serial_b_select_n && !parallel_select_n && !osc16_enable);
   endproperty
   a_sel_same: assert property (p_sel_same) else $error("selects not asserted together");

   property p_resume;
      @(posedge clk) disable iff (sys_rst)
      (s_r.state == SRCC_SUSP && go_res) |=>
         (osc14_enable && osc16_enable && s_r.sel_n == 3'h7 && s_r.sel32 ##1 s_r.sel32);
   endproperty
   a_resume: assert property (p_resume) else $error("resume did not restore oscillators");

   property p_stab;
      @(posedge clk) disable iff (sys_rst)
      (s_r.state == SRCC_SW14) |-> $past(s_r.state) == SRCC_SW14 || $past(s_r.cnt) == STAB_LAST;
   endproperty
   a_stab: assert property (p_stab) else $error("clock switched back before settle time");

   property p_reset_state;
      @(posedge clk)
      $past(sys_rst) |-> (s_r.state == SRCC_RUN && osc14_enable && osc16_enable && !suspended &&
                          serial_a_select_n && serial_b_select_n && parallel_select_n);
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("wrong state after reset");

   property p_other_code;
      @(posedge clk) disable iff (sys_rst)
      (s_r.state == SRCC_SUSP && !go_res) |=> s_r.state == SRCC_SUSP;
   endproperty
   a_other_code: assert property (p_other_code) else $error("suspend left without resume code");

   c_enter_susp: cover property (@(posedge clk) disable iff (sys_rst) $rose(s_r.state == SRCC_SUSP));
   c_back_run: cover property (@(posedge clk) disable iff (sys_rst) $fell(s_r.sel32));
   c_resu_early: cover property (@(posedge clk) disable iff (sys_rst) s_r.state == SRCC_SW32 && go_res);

endmodule // srcc_clock_control

// ### shared/srcc_defines.svh
// timing counts, select codes and reset values for the suspend/resume clock control
`ifndef SRCC_DEFINES_SVH
`define SRCC_DEFINES_SVH

`define SRCC_CLK_PERIOD_NS 4
`define SRCC_REF_PERIOD_NS 15260
`define SRCC_REF_WIDTH_NS 1000
`define SRCC_REF_PERIOD_CYC (`SRCC_REF_PERIOD_NS / `SRCC_CLK_PERIOD_NS)
`define SRCC_REF_WIDTH_CYC (`SRCC_REF_WIDTH_NS / `SRCC_CLK_PERIOD_NS)
`define SRCC_STAB_MS 20
`define SRCC_STAB_CYC (`SRCC_STAB_MS * 1000000 / `SRCC_CLK_PERIOD_NS)

`define SRCC_CODE_W 5
`define SRCC_CODE_SUSPEND 5'h15
`define SRCC_CODE_RESUME 5'h16

`define SRCC_RST_SEL_N 3'h7
`define SRCC_RST_OSC_EN 1'h1

`endif

// ### shared/srcc_pkg.sv
// types shared by the suspend/resume clock control modules
package srcc_pkg;

   typedef enum logic [2:0] {
      SRCC_RUN    = 3'h0,
      SRCC_KILL16 = 3'h1,
      SRCC_SW32   = 3'h2,
      SRCC_SUSP   = 3'h3,
      SRCC_WAKE   = 3'h4,
      SRCC_SW14   = 3'h5
   } srcc_state_t;

   typedef struct packed {
      srcc_state_t state;
      logic sel32;
      logic clk_out;
      logic osc16_en;
      logic osc14_en;
      logic [2:0] sel_n;
      logic [22:0] cnt;
   } srcc_main_t;

   typedef struct packed {
      logic [11:0] cnt;
      logic pulse_n;
   } srcc_ref_t;

endpackage

// ### core/srcc_refresh.sv
// free-running standby refresh pulse generator
`timescale 1ns/1ns
`include "srcc_defines.svh"
module srcc_refresh
   import srcc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // refresh pad
   output logic standby_refresh_pulse_n
);

   localparam logic [11:0] PERIOD = 12'(`SRCC_REF_PERIOD_CYC);
   localparam logic [11:0] WIDTH = 12'(`SRCC_REF_WIDTH_CYC);

   srcc_ref_t r_r;
   srcc_ref_t r_nxt;

   // no suspend input at all: the pulse never stops, whatever the power state
   always_comb begin
      r_nxt = r_r;
      r_nxt.cnt = (r_r.cnt == PERIOD - 12'h001) ? 12'h000 : r_r.cnt + 12'h001;
      r_nxt.pulse_n = !(r_nxt.cnt < WIDTH);
   end

   // registered so the pad never sees a decode glitch
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r_r.cnt <= PERIOD - 12'h001;
         r_r.pulse_n <= 1'h1;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign standby_refresh_pulse_n = r_r.pulse_n;

   // helper: cycles since the last falling edge
   logic [12:0] gap_r;
   logic seen_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gap_r <= 13'h0000;
         seen_r <= 1'h0;
      end else if (!r_r.pulse_n && r_r.cnt == 12'h000) begin
         gap_r <= 13'h0001;
         seen_r <= 1'h1;
      end else begin
         gap_r <= gap_r + 13'h0001;
      end
   end

   property p_ref_width;
      @(posedge clk) disable iff (sys_rst)
      $fell(standby_refresh_pulse_n) |-> ##249 !standby_refresh_pulse_n ##1 standby_refresh_pulse_n;
   endproperty
   a_ref_width: assert property (p_ref_width) else $error("refresh low pulse not 250 cycles");

   property p_ref_period;
      @(posedge clk) disable iff (sys_rst)
      ($fell(standby_refresh_pulse_n) && seen_r) |-> gap_r == 13'h0EE7;
   endproperty
   a_ref_period: assert property (p_ref_period) else $error("refresh period not 3815 cycles");

   property p_ref_alive;
      @(posedge clk) disable iff (sys_rst)
      seen_r |-> gap_r <= 13'h0EE7;
   endproperty
   a_ref_alive: assert property (p_ref_alive) else $error("refresh pulse stopped");

   c_ref_pulse: cover property (@(posedge clk) disable iff (sys_rst) $fell(standby_refresh_pulse_n));

endmodule // srcc_refresh

// ### testbench/srcc_sysctl_model.sv
// system controller model that drives the encoded select bus
`timescale 1ns/1ns
`include "srcc_defines.svh"
module srcc_sysctl_model
   import srcc_pkg::*;
(
   // clock
   input wire logic clk,
   // encoded select bus to the device
   output logic [`SRCC_CODE_W-1:0] select_code,
   output logic io_write_strobe_n,
   // clock and refresh supplied by the device
   input wire logic fast_clk_out,
   input wire logic standby_refresh_pulse_n,
   // refresh the controller drives onto the expansion bus
   output logic bus_refresh_n
);
   // shortened stand-ins for the 1 ms wake wait and the slow-clock edge gap
   localparam int WAKE_EDGES = 2;
   localparam logic [7:0] SLOW_GAP = 8'h20;
   logic busy;
   logic last_clk_r;
   logic slow_r;
   logic [7:0] gap_r;

   initial begin
      select_code = 5'h00;
      io_write_strobe_n = 1'h1;
      busy = 1'h0;
      last_clk_r = 1'h0;
      slow_r = 1'h0;
      gap_r = 8'h00;
   end

   // gap between rising edges of the supplied clock tells the slow source from the fast one
   always @(posedge clk) begin
      last_clk_r <= fast_clk_out;
      if (fast_clk_out && !last_clk_r) begin
         gap_r <= 8'h00;
         slow_r <= (gap_r > SLOW_GAP);
      end else if (gap_r != 8'hFF) begin
         gap_r <= gap_r + 8'h01;
      end
   end

   // parked on the slow clock, the bus refresh copies the standby pulse
   assign bus_refresh_n = slow_r ? standby_refresh_pulse_n : 1'h1;

   // idle bus keeps walking so a stale code never looks like a held request
   always @(posedge clk) begin
      if (!busy) begin
         select_code <= select_code + 5'h03;
      end
   end

   // one write cycle; 15H asks for suspend, 16H for resume after power good
   task automatic send(input logic [`SRCC_CODE_W-1:0] code, input logic strobe_n);
      busy = 1'h1;
      @(posedge clk);
      select_code <= code;
      io_write_strobe_n <= strobe_n;
      @(posedge clk);
      io_write_strobe_n <= 1'h1;
      busy = 1'h0;
      #1;
   endtask

   // wake input seen: wait on the slow clock, then ask for resume
   task automatic wake();
      int seen;
      int waited;
      seen = 0;
      waited = 0;
      while (seen < WAKE_EDGES && waited < 1000) begin
         @(posedge clk);
         waited++;
         if (fast_clk_out && !last_clk_r) seen++;
      end
      send(`SRCC_CODE_RESUME, 1'h0);
   endtask
endmodule // srcc_sysctl_model

// ### testbench/srcc_clock_control_test.sv
// self-checking bench for the suspend/resume clock control
`timescale 1ns/1ns
`include "srcc_defines.svh"
module srcc_clock_control_test
   import srcc_pkg::*;
();
   // short settle count keeps the resume wait small
   localparam int STAB = 20;
   logic clk, sys_rst, osc14_in, osc32_in, pv;
   logic [`SRCC_CODE_W-1:0] select_code;
   logic io_write_strobe_n, osc16_enable, osc14_enable, fast_clk_out, suspended;
   logic serial_a_select_n, serial_b_select_n, parallel_select_n, standby_refresh_pulse_n;
   logic bus_refresh_n;
   int errors, tests_run, cyc, n;

   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   // shortened oscillator levels; a disabled oscillator stops low
   always @(posedge clk) begin
      cyc <= cyc + 1;
      osc14_in <= osc14_enable && ((cyc / 9) % 2 == 1);
      osc32_in <= ((cyc / 24) % 2 == 1);
   end

   srcc_clock_control #(.STAB_CYC(STAB)) dut (
      .clk(clk), .sys_rst(sys_rst), .select_code(select_code), .io_write_strobe_n(io_write_strobe_n),
      .osc14_in(osc14_in), .osc32_in(osc32_in), .osc16_enable(osc16_enable), .osc14_enable(osc14_enable),
      .fast_clk_out(fast_clk_out), .serial_a_select_n(serial_a_select_n),
      .serial_b_select_n(serial_b_select_n), .parallel_select_n(parallel_select_n),
      .standby_refresh_pulse_n(standby_refresh_pulse_n), .suspended(suspended));

   srcc_sysctl_model sysctl (.clk(clk), .select_code(select_code), .io_write_strobe_n(io_write_strobe_n),
      .fast_clk_out(fast_clk_out), .standby_refresh_pulse_n(standby_refresh_pulse_n),
      .bus_refresh_n(bus_refresh_n));

   task automatic tick();
      @(posedge clk);
      #1;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic timeout(input string what);
      errors++;
      $display("BAD %s expected done seen timeout", what);
      wrap_up();
   endtask

   // selects, oscillator enables and status together
   task automatic chk_state(input logic [2:0] sel, input logic [1:0] osc, input logic susp);
      chk("selects", {serial_a_select_n, serial_b_select_n, parallel_select_n}, sel);
      chk("osc_enables", {osc16_enable, osc14_enable}, osc);
      chk("suspended", suspended, susp);
   endtask

   // output trails the selected source by one cycle
   task automatic chk_follow(input logic use32);
      for (int i = 0; i < 60; i++) begin
         @(posedge clk);
         pv = use32 ? osc32_in : osc14_in;
         #1;
         chk("fast_clk_out", fast_clk_out, pv);
      end
   endtask

   // one refresh period: low width, then fall to fall, in clk cycles
   task automatic meas_ref();
      int lo;
      int hi;
      lo = 0;
      hi = 0;
      // the pulse may already be low here: sync to a whole low pulse first
      for (n = 0; n < 400 && standby_refresh_pulse_n !== 1'h1; n++) tick();
      if (n == 400) timeout("refresh_rise");
      for (n = 0; n < 4000 && standby_refresh_pulse_n !== 1'h0; n++) tick();
      if (n == 4000) timeout("refresh_fall");
      while (standby_refresh_pulse_n === 1'h0 && lo < 400) begin
         tick();
         lo++;
      end
      while (standby_refresh_pulse_n === 1'h1 && hi < 4000) begin
         tick();
         hi++;
      end
      chk("refresh_low_cycles", lo, `SRCC_REF_WIDTH_CYC);
      chk("refresh_period_cycles", lo + hi, `SRCC_REF_PERIOD_CYC);
   endtask

   // unstrobed suspend, resume while running and stray codes change nothing
   task automatic t_ignore();
      sysctl.send(`SRCC_CODE_SUSPEND, 1'h1);
      sysctl.send(`SRCC_CODE_RESUME, 1'h0);
      sysctl.send(5'h14, 1'h0);
      sysctl.send(5'h17, 1'h0);
      repeat (4) tick();
      chk_state(3'h7, 2'h3, 1'h0);
   endtask

   // suspend order: selects and 16 MHz off first, switch, then 14 MHz off
   task automatic t_suspend();
      sysctl.send(`SRCC_CODE_SUSPEND, 1'h0);
      chk_state(3'h0, 2'h1, 1'h0);
      for (n = 0; n < 200 && suspended !== 1'h1; n++) tick();
      if (n == 200) timeout("suspend");
      chk("osc14_before_switch", osc14_enable, 1'h1);
      tick();
      chk_state(3'h0, 2'h0, 1'h1);
      chk_follow(1'h1);
      sysctl.send(`SRCC_CODE_SUSPEND, 1'h0);
      sysctl.send(5'h0A, 1'h0);
      chk_state(3'h0, 2'h0, 1'h1);
      meas_ref();
      chk_state(3'h0, 2'h0, 1'h1);
      chk("bus_refresh_copy", bus_refresh_n, standby_refresh_pulse_n);
   endtask

   // resume: enables and selects at once, fast clock only after the settle wait
   task automatic t_resume();
      int k;
      sysctl.wake();
      chk_state(3'h7, 2'h3, 1'h1);
      for (k = 1; k < STAB + 200 && suspended !== 1'h0; k++) tick();
      chk("settle_wait_kept", k >= STAB + 2, 1'h1);
      chk("resumed", suspended, 1'h0);
      chk_follow(1'h0);
      chk("bus_refresh_normal", bus_refresh_n, 1'h1);
   endtask

   // resume while the switch waits aborts it; suspend in the settle wait is taken at once
   task automatic t_abort();
      sysctl.send(`SRCC_CODE_SUSPEND, 1'h0);
      sysctl.send(`SRCC_CODE_RESUME, 1'h0);
      chk_state(3'h7, 2'h3, 1'h0);
      sysctl.send(`SRCC_CODE_SUSPEND, 1'h0);
      chk_state(3'h0, 2'h1, 1'h0);
      for (n = 0; n < 200 && suspended !== 1'h1; n++) tick();
      if (n == 200) timeout("suspend_again");
      tick();
      chk_state(3'h0, 2'h0, 1'h1);
   endtask

   initial begin
      sys_rst = 1'h1;
      errors = 0;
      tests_run = 0;
      cyc = 0;
      osc14_in = 1'h0;
      osc32_in = 1'h0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'h0;
      #1;
      chk_state(3'h7, 2'h3, 1'h0);
      chk_follow(1'h0);
      meas_ref();
      t_ignore();
      t_suspend();
      t_resume();
      t_abort();
      t_resume();
      wrap_up();
   end
endmodule // srcc_clock_control_test
